// [inc/sbic_pkg.sv]
// Package: register map, field positions, resets and timing of serial port B
`default_nettype none
package sbic_pkg;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] ADDR_ACT     = 8'h30;
  localparam logic [7:0] ADDR_BASE_HI = 8'h60;
  localparam logic [7:0] ADDR_BASE_LO = 8'h61;
  localparam logic [7:0] ADDR_IRQ     = 8'h70;
  localparam logic [7:0] ADDR_OPT     = 8'hF0;
  localparam logic [7:0] ADDR_IRC     = 8'hF1;
  localparam logic [7:0] ADDR_STAT    = 8'hF2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_ACT     = 8'h01;
  localparam logic [7:0] RST_BASE_HI = 8'h02;
  localparam logic [7:0] RST_BASE_LO = 8'hF8;
  localparam logic [7:0] RST_IRQ     = 8'h03;
  localparam logic [7:0] RST_OPT     = 8'h00;
  localparam logic [7:0] RST_IRC     = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OPT_NODLY  = 7;
  localparam int OPT_PULSE  = 6;
  localparam int OPT_NEWERR = 5;
  localparam int OPT_RXDLY  = 3;
  localparam int OPT_TXDLY  = 2;
  localparam int IRC_LOC    = 6;
  localparam int IRC_MODE   = 3;
  localparam int IRC_HALF   = 2;
  localparam int IRC_TXINV  = 1;
  localparam int IRC_RXINV  = 0;
  localparam logic [7:0] OPT_MASK = 8'hEF;
  // ----------------------------------------
  // I/O window limits
  // ----------------------------------------
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX = 16'h0FF8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int IRDA_PULSE_NS  = 1600;
  localparam int IRDA_PULSE_CYC = (IRDA_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int ASK_CARRIER_HZ = 500_000;
  localparam int ASK_HALF_CYC   = CLK_HZ / (2 * ASK_CARRIER_HZ);
  localparam int TURN_BIT_TIMES = 40;
  localparam int IRDA_FRAC_NUM  = 3;
  localparam int OVERSAMPLE     = 16;
  // ----------------------------------------
  // Infrared function codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    IR_OFF0  = 3'h0,
    IR_OFF1  = 3'h1,
    IRDA_FIX = 3'h2,
    IRDA_FRC = 3'h3,
    ASK_PASS = 3'h4,
    ASK_CPAS = 3'h5,
    ASK_DEM  = 3'h6,
    ASK_CDEM = 3'h7
  } sbic_ir_mode_t;
  // Link direction, Gray coded around the loop
  typedef enum logic [1:0] {
    DIR_RX    = 2'h0,
    DIR_TXDLY = 2'h1,
    DIR_TX    = 2'h3,
    DIR_RXDLY = 2'h2
  } sbic_dir_t;
endpackage
`default_nettype wire

// [src/sbic_top.sv]
// Serial port B configuration, interrupt routing and infrared front end
// How it works
// - The I/O window is an 8-byte block at the 16-bit base, valid from 100h to FF8h.
// - The interrupt goes to the line numbered by select bits 3-0, to no line for code 0; upper bits read zero.
// - Option bit 6 clear gives a level interrupt, set gives a pulse.
// - Option bit 5 picks the legacy or the new receive FIFO error signal.
// - Option bit 3 holds reception off 40 bit times after transmit turns to receive, on a half-duplex infrared link only.
// - Option bit 2 holds transmission off 40 bit times after receive turns to transmit, on a half-duplex infrared link only.
// - Option bits 1-0 choose the baud clock source divided from 24 MHz.
// - Control bit 6 moves infrared from the serial pins to the dedicated pins.
// - Function codes 00X disable infrared: infrared transmit tri-stated, receive taken from the serial pin.
// - IrDA codes send a 1.6 us or 3/16 bit pulse per zero bit and demodulate receive.
// - ASK codes invert transmit, 101 and 111 add a 500 kHz carrier, 11X demodulate.
// - Control bit 2 clear is full duplex, set is half duplex.
// - Control bit 1 inverts the transmit pin.
// - Control bit 0 inverts the receive pin.
//
// Local design decision: the address-and-strobe port.
`default_nettype none
module sbic_top #(
  parameter int TURN_BITS = sbic_pkg::TURN_BIT_TIMES,
  parameter int OS        = sbic_pkg::OVERSAMPLE
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [15:0] io_addr_in,
  output logic             io_select_out,
  input  wire logic        uart_irq_in,
  output logic      [15:0] irq_lines_out,
  input  wire logic        rx_err_legacy_in,
  input  wire logic        rx_err_new_in,
  output logic             rx_err_out,
  output logic      [1:0]  baud_src_sel_out,
  output logic             rxclk_nodelay_out,
  input  wire logic        baud16_tick_in,
  input  wire logic        uart_tx_active_in,
  output logic             tx_hold_out,
  input  wire logic        uart_txd_in,
  output logic             uart_rxd_out,
  output logic             serial_out_b_out,
  output logic             serial_out_b_oe_out,
  input  wire logic        serial_in_b_in,
  output logic             infrared_transmit_pin_out,
  output logic             infrared_transmit_pin_oe_out,
  input  wire logic        infrared_receive_pin_in
);
  localparam int TURN_TICKS = TURN_BITS * OS;
  localparam int TW         = $clog2(TURN_TICKS + 1);
  localparam int PW         = $clog2(OS);
  localparam int CW         = $clog2(sbic_pkg::IRDA_PULSE_CYC + 1);
  localparam int AW         = $clog2(sbic_pkg::ASK_HALF_CYC + 1);

  // Oversample must be a power of two so the bit phase wraps on its own
  if (OS < 4 || (OS & (OS - 1)) != 0 || TURN_BITS < 1) begin : g_chk
    $error("sbic_top: OS must be a power of two >= 4 and TURN_BITS >= 1");
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] act;
  logic [7:0] base_hi;
  logic [7:0] base_lo;
  logic [7:0] irq_sel;
  logic [7:0] opt;
  logic [7:0] irc;
  logic [7:0] status;

  // Reserved bits of the activate, interrupt select and option registers are not stored, so they read back zero
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      act     <= sbic_pkg::RST_ACT;
      base_hi <= sbic_pkg::RST_BASE_HI;
      base_lo <= sbic_pkg::RST_BASE_LO;
      irq_sel <= sbic_pkg::RST_IRQ;
      opt     <= sbic_pkg::RST_OPT;
      irc     <= sbic_pkg::RST_IRC;
    end
    else if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        sbic_pkg::ADDR_ACT:     act     <= reg_wdata_in & 8'h01;
        sbic_pkg::ADDR_BASE_HI: base_hi <= reg_wdata_in;
        sbic_pkg::ADDR_BASE_LO: base_lo <= reg_wdata_in;
        sbic_pkg::ADDR_IRQ:     irq_sel <= reg_wdata_in & 8'h0F;
        sbic_pkg::ADDR_OPT:     opt     <= reg_wdata_in & sbic_pkg::OPT_MASK;
        sbic_pkg::ADDR_IRC:     irc     <= reg_wdata_in;
        default:                ;
      endcase
    end
  end

  // Read mux; unmapped indices read zero
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      sbic_pkg::ADDR_ACT:     reg_read = act;
      sbic_pkg::ADDR_BASE_HI: reg_read = base_hi;
      sbic_pkg::ADDR_BASE_LO: reg_read = base_lo;
      sbic_pkg::ADDR_IRQ:     reg_read = irq_sel;
      sbic_pkg::ADDR_OPT:     reg_read = opt;
      sbic_pkg::ADDR_IRC:     reg_read = irc;
      sbic_pkg::ADDR_STAT:    reg_read = status;
      default:                reg_read = 8'h00;
    endcase
  endfunction

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else
      reg_rdata_out <= reg_rd_in ? reg_read(reg_addr_in) : 8'h00;
  end

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  sbic_pkg::sbic_ir_mode_t mode;
  logic        active;
  logic        ir_on;
  logic        half;
  logic        loc;
  logic [15:0] base;
  logic        base_ok;

  assign active  = act[0];
  assign mode    = sbic_pkg::sbic_ir_mode_t'(irc[sbic_pkg::IRC_MODE +: 3]);
  assign ir_on   = active && (mode[2:1] != 2'h0);
  assign half    = irc[sbic_pkg::IRC_HALF];
  assign loc     = irc[sbic_pkg::IRC_LOC];
  assign base    = {base_hi, base_lo};
  assign base_ok = (base >= sbic_pkg::BASE_MIN) && (base <= sbic_pkg::BASE_MAX);

  // Window match ignores the low three bits, forcing 8-byte alignment
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      io_select_out <= 1'b0;
    else
      io_select_out <= active && base_ok && (io_addr_in[15:3] == base[15:3]);
  end

  // ----------------------------------------
  // Interrupt and side options
  // ----------------------------------------
  logic irq_prev;
  logic irq_evt;

  // Pulse mode fires once on the rising edge of the core request
  assign irq_evt = opt[sbic_pkg::OPT_PULSE] ? (uart_irq_in && !irq_prev) : uart_irq_in;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      irq_prev      <= 1'b0;
      irq_lines_out <= 16'h0000;
    end
    else
    begin
      irq_prev      <= uart_irq_in;
      // Select code 0 means no line, since line 0 is not shareable
      irq_lines_out <= (active && irq_evt && irq_sel[3:0] != 4'h0) ? (16'h0001 << irq_sel[3:0]) : 16'h0000;
    end
  end

  // Side options are passed on registered to the UART core
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      rx_err_out        <= 1'b0;
      baud_src_sel_out  <= 2'h0;
      rxclk_nodelay_out <= 1'b0;
    end
    else
    begin
      rx_err_out        <= opt[sbic_pkg::OPT_NEWERR] ? rx_err_new_in : rx_err_legacy_in;
      baud_src_sel_out  <= opt[1:0];
      rxclk_nodelay_out <= opt[sbic_pkg::OPT_NODLY];
    end
  end

  // ----------------------------------------
  // Half-duplex turnaround
  // ----------------------------------------
  sbic_pkg::sbic_dir_t dir;
  logic [TW-1:0]       turn_cnt;
  logic                turn_done;
  logic                dly_ok;

  // Delays only make sense on a half-duplex infrared link
  assign dly_ok    = ir_on && half;
  assign turn_done = baud16_tick_in && (turn_cnt == TW'(TURN_TICKS - 1));

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      dir <= sbic_pkg::DIR_RX;
    else
    begin
      unique case (dir)
        sbic_pkg::DIR_RX:
          if (uart_tx_active_in)
            dir <= (dly_ok && opt[sbic_pkg::OPT_TXDLY]) ? sbic_pkg::DIR_TXDLY : sbic_pkg::DIR_TX;
        sbic_pkg::DIR_TXDLY:
          if (!uart_tx_active_in)
            dir <= sbic_pkg::DIR_RX;
          else if (turn_done)
            dir <= sbic_pkg::DIR_TX;
        sbic_pkg::DIR_TX:
          if (!uart_tx_active_in)
            dir <= (dly_ok && opt[sbic_pkg::OPT_RXDLY]) ? sbic_pkg::DIR_RXDLY : sbic_pkg::DIR_RX;
        sbic_pkg::DIR_RXDLY:
          if (turn_done)
            dir <= sbic_pkg::DIR_RX;
      endcase
    end
  end

  // Counts oversample ticks while a turnaround hold is running
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      turn_cnt <= '0;
    else if (dir != sbic_pkg::DIR_TXDLY && dir != sbic_pkg::DIR_RXDLY)
      turn_cnt <= '0;
    else if (baud16_tick_in)
      turn_cnt <= turn_cnt + TW'(1);
  end

  assign tx_hold_out = (dir == sbic_pkg::DIR_TXDLY);
  assign status      = {4'h0, dir == sbic_pkg::DIR_RXDLY, tx_hold_out, ir_on, active};

  // ----------------------------------------
  // Infrared transmit
  // ----------------------------------------
  logic [PW-1:0] phase;
  logic          txd_prev;
  logic [CW-1:0] pulse_cnt;
  logic [AW-1:0] car_cnt;
  logic          carrier;
  logic          ir_tx;

  // Bit phase resyncs on every data edge so pulses sit at bit starts
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      txd_prev <= 1'b1;
      phase    <= '0;
    end
    else
    begin
      txd_prev <= uart_txd_in;
      if (uart_txd_in != txd_prev)
        phase <= '0;
      else if (baud16_tick_in)
        phase <= phase + PW'(1);
    end
  end

  // Fixed-width pulse counter, launched at the start of each zero bit
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      pulse_cnt <= '0;
    else if (!uart_txd_in && (txd_prev || (baud16_tick_in && phase == PW'(OS - 1))))
      pulse_cnt <= CW'(sbic_pkg::IRDA_PULSE_CYC);
    else if (pulse_cnt != '0)
      pulse_cnt <= pulse_cnt - CW'(1);
  end

  // Free-running carrier toggled every half period
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      car_cnt <= '0;
      carrier <= 1'b0;
    end
    else if (car_cnt == AW'(sbic_pkg::ASK_HALF_CYC - 1))
    begin
      car_cnt <= '0;
      carrier <= !carrier;
    end
    else
      car_cnt <= car_cnt + AW'(1);
  end

  // Light-on level per function code
  always_comb
  begin
    unique case (mode)
      sbic_pkg::IRDA_FIX: ir_tx = (pulse_cnt != '0);
      sbic_pkg::IRDA_FRC: ir_tx = !uart_txd_in && (phase < PW'(sbic_pkg::IRDA_FRAC_NUM));
      sbic_pkg::ASK_PASS,
      sbic_pkg::ASK_DEM:  ir_tx = !uart_txd_in;
      sbic_pkg::ASK_CPAS,
      sbic_pkg::ASK_CDEM: ir_tx = !uart_txd_in && carrier;
      default:            ir_tx = 1'b0;
    endcase
  end

  // Pin drivers; the idle serial pin holds mark, inverted by control bit 1, while infrared owns the link
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      serial_out_b_out             <= 1'b1;
      serial_out_b_oe_out          <= 1'b0;
      infrared_transmit_pin_out    <= 1'b0;
      infrared_transmit_pin_oe_out <= 1'b0;
    end
    else
    begin
      serial_out_b_oe_out          <= active;
      infrared_transmit_pin_oe_out <= ir_on && loc;
      infrared_transmit_pin_out    <= ir_tx ^ irc[sbic_pkg::IRC_TXINV];
      if (ir_on && !loc)
        serial_out_b_out <= ir_tx ^ irc[sbic_pkg::IRC_TXINV];
      else if (ir_on)
        serial_out_b_out <= !irc[sbic_pkg::IRC_TXINV];
      else
        serial_out_b_out <= uart_txd_in ^ irc[sbic_pkg::IRC_TXINV];
    end
  end

  // ----------------------------------------
  // Infrared receive
  // ----------------------------------------
  logic          rx_raw;
  logic [PW:0]   strch;
  logic          rx_dem;
  logic          rx_blk;

  assign rx_raw = ((ir_on && loc) ? infrared_receive_pin_in : serial_in_b_in) ^ irc[sbic_pkg::IRC_RXINV];

  // Each received low pulse stretches into one full bit of zero
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      strch <= '0;
    else if (!rx_raw)
      strch <= (PW + 1)'(OS);
    else if (baud16_tick_in && strch != '0)
      strch <= strch - (PW + 1)'(1);
  end

  assign rx_dem = ir_on && mode[1] ? (strch == '0) : rx_raw;
  // Half duplex ignores own echo and the post-transmit hold window
  assign rx_blk = dly_ok && (dir != sbic_pkg::DIR_RX);

  // Receive seen by the core idles high when off or blocked
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      uart_rxd_out <= 1'b1;
    else
      uart_rxd_out <= !active || rx_blk || rx_dem;
  end
endmodule
`default_nettype wire

// [dv/sbic_top_assertions.sv]
// Checker for the register bus, interrupt routing and option outputs
`default_nettype none
module sbic_top_checker (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        io_select_out,
  input wire logic        uart_irq_in,
  input wire logic [15:0] irq_lines_out,
  input wire logic        rx_err_legacy_in,
  input wire logic        rx_err_new_in,
  input wire logic        rx_err_out,
  input wire logic [1:0]  baud_src_sel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       act;
  logic [3:0] irq;
  logic [7:0] opt;
  // ----
  // Shadow registers
  // ----
  // Mirror of written values, so no peeking inside the design is needed
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      act <= 1'b1;
      irq <= 4'h3;
      opt <= 8'h00;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == sbic_pkg::ADDR_ACT) act <= reg_wdata_in[0];
      if (reg_addr_in == sbic_pkg::ADDR_IRQ) irq <= reg_wdata_in[3:0];
      if (reg_addr_in == sbic_pkg::ADDR_OPT) opt <= reg_wdata_in & 8'hEF;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ----
  // Properties
  // ----
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not idle");
  a_act_read: assert property ($past(reg_rd_in && reg_addr_in == sbic_pkg::ADDR_ACT)
    |-> reg_rdata_out == {7'h00, $past(act)}) else $error("activate read wrong");
  a_irq_read: assert property ($past(reg_rd_in && reg_addr_in == sbic_pkg::ADDR_IRQ)
    |-> reg_rdata_out == {4'h0, $past(irq)}) else $error("irq select read wrong");
  a_irq_route: assert property ($past(!rst_in && !opt[6]) |-> irq_lines_out ==
    ($past(act && uart_irq_in && irq != 4'h0) ? 16'h0001 << $past(irq) : 16'h0000))
    else $error("irq line wrong");
  a_irq_pulse: assert property (opt[6] && irq_lines_out != 16'h0000 |=> irq_lines_out == 16'h0000)
    else $error("pulse irq too long");
  a_select_off: assert property (!act |=> !io_select_out)
    else $error("decode while inactive");
  a_err_select: assert property ($past(!rst_in) |->
    rx_err_out == $past(opt[5] ? rx_err_new_in : rx_err_legacy_in)) else $error("error source wrong");
  a_baud_copy: assert property (reg_wr_in && reg_addr_in == sbic_pkg::ADDR_OPT |->
    ##2 baud_src_sel_out == $past(reg_wdata_in[1:0], 2)) else $error("baud select wrong");
  c_pulse: cover property (opt[6] && irq_lines_out != 16'h0000);
  c_select: cover property (io_select_out);
  c_top_line: cover property (irq_lines_out == 16'h8000);
endmodule
bind sbic_top sbic_top_checker sbic_top_checker_i (.*);
`default_nettype wire

// [dv/sbic_line_model.sv]
// Far-side line model driving the receive pins of port B
`default_nettype none
module sbic_line_model (
  input  wire logic line_level_in,
  output logic      serial_in_b_out,
  output logic      ir_rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both receivers see one commanded level; a quiet line idles at mark
  assign serial_in_b_out = line_level_in;
  assign ir_rx_out       = line_level_in;
endmodule
`default_nettype wire

// [dv/serial_port_b_infrared_config_test.sv]
// Testbench for serial port B configuration and infrared front end
`default_nettype none
module serial_port_b_infrared_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_in, rst_in, reg_wr_in, reg_rd_in, uart_irq_in, io_select_out;
  logic        rx_err_legacy_in, rx_err_new_in, rx_err_out, rxclk_nodelay_out;
  logic        baud16_tick_in, uart_tx_active_in, tx_hold_out, uart_txd_in, uart_rxd_out;
  logic        serial_out_b_out, serial_out_b_oe_out, serial_in_b_in, line_level;
  logic        infrared_transmit_pin_out, infrared_transmit_pin_oe_out, infrared_receive_pin_in;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [15:0] io_addr_in, irq_lines_out;
  logic [1:0]  baud_src_sel_out, tc;
  logic [7:0]  ra [8], rv [8], rf [8];
  int          err_total, check_count, n, k;
  // Short turnaround keeps the run brief: 32 ticks of hold
  sbic_top #(.TURN_BITS(2)) sbic_top_i (.*);
  sbic_line_model sbic_line_model_i (.line_level_in(line_level), .serial_in_b_out(serial_in_b_in),
                                     .ir_rx_out(infrared_receive_pin_in));
  // ----
  // Clock and baud ticks
  // ----
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // One tick every four cycles
  // Restarts with reset so the tick counter has a single driver
  always @(posedge sys_clk_in)
  begin
    tc <= rst_in ? 2'h0 : tc + 2'h1;
    baud16_tick_in <= !rst_in && (tc == 2'h0);
  end
  // ----
  // Tasks
  // ----
  task go(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    go(1);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    go(1);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    go(1);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    go(1);
    reg_rd_in <= 1'b0;
    #1 chk(16'(reg_rdata_out), 16'(e));
  endtask
  task io(input logic [15:0] a, input logic e);
    go(1);
    io_addr_in <= a;
    go(2);
    #1 chk(16'(io_select_out), 16'(e));
  endtask
  // Counts cycles high: 0 infrared pin, 1 transmit hold, 2 receive to core
  task cnt(input int w, input int c);
    n = 0;
    repeat (c)
    begin
      go(1);
      #1 n += (w == 0) ? int'(infrared_transmit_pin_out) : (w == 1) ? int'(tx_hold_out) : int'(uart_rxd_out);
    end
  endtask
  task reset;
    go(1);
    rst_in <= 1'b1;
    go(2);
    rst_in <= 1'b0;
  endtask
  task summarize;
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    {rst_in, reg_wr_in, reg_rd_in, uart_irq_in, rx_err_legacy_in, rx_err_new_in} = 6'h20;
    {uart_tx_active_in, uart_txd_in, line_level} = 3'h3;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    io_addr_in = 16'h0000;
    err_total = 0;
    check_count = 0;
    ra = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hF0, 8'hF1, 8'h55, 8'hF2};
    rv = '{8'h01, 8'h02, 8'hF8, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    rf = '{8'h01, 8'hFF, 8'hFF, 8'h0F, 8'hEF, 8'hFF, 8'h00, 8'h03};
    reset;
    for (k = 0; k < 8; k++) rd(ra[k], rv[k]);
    for (k = 0; k < 8; k++) wr(ra[k], 8'hFF);
    for (k = 0; k < 8; k++) rd(ra[k], rf[k]);
    reset;
    // Window edges, out-of-range bases and the activate gate
    io(16'h02F8, 1'b1);
    io(16'h02FF, 1'b1);
    io(16'h0300, 1'b0);
    io(16'h02F7, 1'b0);
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h80);
    io(16'h0080, 1'b0);
    wr(8'h60, 8'h10);
    wr(8'h61, 8'h00);
    io(16'h1000, 1'b0);
    wr(8'h60, 8'h0F);
    wr(8'h61, 8'hF8);
    io(16'h0FFF, 1'b1);
    wr(8'h30, 8'h00);
    io(16'h0FF8, 1'b0);
    wr(8'h30, 8'h01);
    // Every interrupt line, then the inactive gate, then pulse mode
    uart_irq_in <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      wr(8'h70, 8'(k));
      go(1);
      #1 chk(irq_lines_out, (k == 0) ? 16'h0000 : 16'h0001 << k);
    end
    wr(8'h70, 8'h03);
    wr(8'h30, 8'h00);
    go(1);
    #1 chk(irq_lines_out, 16'h0000);
    wr(8'h30, 8'h01);
    uart_irq_in <= 1'b0;
    wr(8'h70, 8'h03);
    wr(8'hF0, 8'h40);
    uart_irq_in <= 1'b1;
    n = 0;
    repeat (6)
    begin
      go(1);
      #1 n += int'(irq_lines_out == 16'h0008);
    end
    chk(16'(n), 16'h0001);
    uart_irq_in <= 1'b0;
    // Error source and baud clock codes
    rx_err_legacy_in <= 1'b1;
    wr(8'hF0, 8'h00);
    go(1);
    #1 chk(16'(rx_err_out), 16'h0001);
    wr(8'hF0, 8'h20);
    go(1);
    #1 chk(16'(rx_err_out), 16'h0000);
    rx_err_legacy_in <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      wr(8'hF0, 8'(k));
      go(1);
      #1 chk(16'(baud_src_sel_out), 16'(k));
    end
    wr(8'hF0, 8'h80);
    go(1);
    #1 chk(16'(rxclk_nodelay_out), 16'h0001);
    // Pin polarity and infrared function codes
    uart_txd_in <= 1'b0;
    wr(8'hF1, 8'h00);
    go(1);
    #1 chk(16'({serial_out_b_oe_out, serial_out_b_out}), 16'h0002);
    wr(8'hF1, 8'h02);
    go(1);
    #1 chk(16'(serial_out_b_out), 16'h0001);
    line_level <= 1'b0;
    wr(8'hF1, 8'h01);
    go(1);
    #1 chk(16'(uart_rxd_out), 16'h0001);
    wr(8'hF1, 8'h40);
    go(1);
    #1 chk(16'(infrared_transmit_pin_oe_out), 16'h0000);
    wr(8'hF1, 8'h60);
    go(1);
    #1 chk(16'({infrared_transmit_pin_oe_out, infrared_transmit_pin_out, uart_rxd_out}), 16'h0006);
    wr(8'hF1, 8'h68);
    cnt(0, 400);
    chk(16'(n), 16'd200);
    uart_txd_in <= 1'b1;
    wr(8'hF1, 8'h50);
    go(200);
    uart_txd_in <= 1'b0;
    go(1);
    uart_txd_in <= 1'b1;
    cnt(0, 300);
    chk(16'(n), 16'd160);
    // A steady zero gives 3 of 16 ticks of light per bit, 64 cycles a bit
    wr(8'hF1, 8'h58);
    uart_txd_in <= 1'b0;
    go(2);
    cnt(0, 256);
    chk(16'(n), 16'd48);
    // Demodulated receive stays low for one stretched bit after the light ends
    wr(8'hF1, 8'h70);
    line_level <= 1'b1;
    cnt(2, 100);
    chk(16'(n >= 36 && n <= 39), 16'h0001);
    line_level <= 1'b0;
    // Half-duplex turnarounds, then no delay and full duplex
    wr(8'hF1, 8'h24);
    wr(8'hF0, 8'h0C);
    uart_tx_active_in <= 1'b1;
    cnt(1, 200);
    chk(16'(n >= 124 && n <= 132), 16'h0001);
    uart_tx_active_in <= 1'b0;
    cnt(2, 200);
    chk(16'(n >= 124 && n <= 132), 16'h0001);
    wr(8'hF0, 8'h00);
    uart_tx_active_in <= 1'b1;
    cnt(1, 50);
    chk(16'(n), 16'h0000);
    uart_tx_active_in <= 1'b0;
    wr(8'hF1, 8'h20);
    wr(8'hF0, 8'h0C);
    uart_tx_active_in <= 1'b1;
    cnt(1, 50);
    chk(16'(n), 16'h0000);
    summarize;
  end
  // Cuts a hang short well past the expected run time
  initial
  begin
    #200us;
    err_total++;
    summarize;
  end
endmodule
`default_nettype wire
